// file: pkg/bdma_consts.vh
// bdma_consts.vh: offsets, field positions, reset values and variant codes of the banked memory decoder
`ifndef BDMA_CONSTS_VH
`define BDMA_CONSTS_VH

// =============================================================
// global register locations
`define BDMA_LOC_INDIRECT_WINDOW   8'h00
`define BDMA_LOC_REAL_TIME_COUNTER 8'h01
`define BDMA_LOC_PROGRAM_COUNTER   8'h02
`define BDMA_LOC_STATUS_FLAGS      8'h03
`define BDMA_LOC_FILE_SELECT       8'h04
`define BDMA_LOC_PORT_A            8'h05
`define BDMA_LOC_PORT_B            8'h06
`define BDMA_LOC_PORT_C            8'h07
`define BDMA_LOC_EXTRA_GP          8'h08

// =============================================================
// operand field layout
`define BDMA_OPND_W          5
`define BDMA_OPND_BANKED_BIT 4
`define BDMA_OPND_INDIRECT   5'h00

// =============================================================
// pointer layout and reset
`define BDMA_PTR_RESET        8'h00
`define BDMA_SMALL_BANK_MASK  8'he0
`define BDMA_LARGE_BANK_MASK  8'h70
`define BDMA_LARGE_BLOCK_BIT  7

// =============================================================
// physical space: 0x000-0x0ff banked/flat, 0x100-0x10f global bank (large)
`define BDMA_PADDR_W      9
`define BDMA_GLOBAL_BASE  9'h100

// =============================================================
// variant codes
`define BDMA_VARIANT_SMALL 0
`define BDMA_VARIANT_LARGE 1

`endif

// file: verilog/bdma_addr_decode.v
// bdma_addr_decode.v: combinational operand/pointer to physical address decoder
`include "bdma_consts.vh"

module bdma_addr_decode #(
    parameter VARIANT = `BDMA_VARIANT_SMALL
) (
    // operand and pointer
    input  wire [4:0] opnd_i,
    input  wire [7:0] ptr_i,
    // decoded physical address
    output reg  [8:0] paddr_o,
    output reg        indirect_o
);

    reg [7:0] eff;

    always @* begin
        eff        = 8'h00;
        indirect_o = (opnd_i == `BDMA_OPND_INDIRECT);
        paddr_o    = 9'h000;
        if (VARIANT == `BDMA_VARIANT_SMALL) begin
            // small map: flat 8-bit space, globals folded into bank 0
            if (opnd_i == `BDMA_OPND_INDIRECT)
                eff = ptr_i;                                            // [RULE8]
            else if (!opnd_i[`BDMA_OPND_BANKED_BIT])
                eff = {3'h0, opnd_i};                                   // [RULE9] [RULE6]
            else
                eff = {ptr_i[7:5], opnd_i};                             // [RULE10] [RULE3] [RULE7]
            // pointer low bits 00-0f in any bank alias the globals
            if (!eff[4])
                eff = {4'h0, eff[3:0]};                                 // [RULE6]
            paddr_o = {1'b0, eff};                                      // [RULE2]
        end else begin
            if (opnd_i == `BDMA_OPND_INDIRECT) begin
                // bank 0 unreachable: pointer 00-0f lands in the global bank
                if (ptr_i[7:4] == 4'h0)
                    paddr_o = `BDMA_GLOBAL_BASE | {5'h00, ptr_i[3:0]};  // [RULE14] [RULE20]
                else
                    paddr_o = {1'b0, ptr_i};                            // [RULE14] [RULE20] [RULE21]
            end else if (!opnd_i[`BDMA_OPND_BANKED_BIT])
                paddr_o = `BDMA_GLOBAL_BASE | {5'h00, opnd_i[3:0]};     // [RULE15] [RULE13]
            else
                paddr_o = {1'b0, ptr_i[7:4], opnd_i[3:0]};              // [RULE16] [RULE13] [RULE21]
        end
    end

endmodule

// file: verilog/bdma_pointer.v
// bdma_pointer.v: file select pointer register with bank-select and full writes
`include "bdma_consts.vh"

module bdma_pointer #(
    parameter VARIANT = `BDMA_VARIANT_SMALL
) (
    // clock and reset
    input  wire       mclk_i,
    input  wire       reset_n_i,
    input  wire       clk_en_i,
    // updates
    input  wire       full_we_i,
    input  wire [7:0] full_data_i,
    input  wire       bank_we_i,
    input  wire [7:0] bank_data_i,
    // state
    output reg  [7:0] ptr_o
);

    localparam [7:0] MASK = (VARIANT == `BDMA_VARIANT_SMALL) ?
                            `BDMA_SMALL_BANK_MASK : `BDMA_LARGE_BANK_MASK;

    reg [7:0] ptr_next;

    always @* begin
        ptr_next = ptr_o;
        // full write wins over bank-select when both arrive together
        if (full_we_i)
            ptr_next = full_data_i;                                     // [RULE19]
        else if (bank_we_i)
            ptr_next = (ptr_o & ~MASK) | (bank_data_i & MASK);          // [RULE4] [RULE17] [RULE18]
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            ptr_o <= `BDMA_PTR_RESET;                                   // [RULE5]
        else if (clk_en_i)
            ptr_o <= ptr_next;
    end

endmodule

// file: verilog/bdma_banked_mem.v
// bdma_banked_mem.v: banked data memory with pointer register and operand decoding
//
// Function
// RULE1 - small variant: eight banks, 136 general registers plus eight dedicated ones.
// RULE2 - every access carries a 5-bit operand, combined with the pointer except for direct operands 01-0f.
// RULE3 - small variant: pointer top three bits choose the bank.
// RULE4 - bank-select changes only bank bits of the pointer.
// RULE5 - after reset the pointer selects bank 0.
// RULE6 - small variant: locations 00-0f of any bank always hit the sixteen globals.
// RULE7 - small variant: operands 10-1f hit sixteen per-bank registers, 128 total.
// RULE8 - pointer lives at 04h; operand 00h uses the full pointer as address.
// RULE9 - small variant: operands 01-0f hit bank 0 globals, pointer ignored.
// RULE10 - small variant: 10-1f use pointer top three bits plus five operand bits.
// RULE11 - small parts without port C get a general register at 07h.
// RULE12 - small variant: 00-07 dedicated, 08-0f general purpose.
// RULE13 - large variant: indirect 00h, direct 01-0f, semi-direct 10-1f.
// RULE14 - large indirect reaches global bank and banks 1-f, not bank 0.
// RULE15 - large direct selects the global bank only, pointer ignored.
// RULE16 - large semi-direct: pointer high nibble plus operand low nibble.
// RULE17 - large bank-select writes pointer bits 4, 5 and 6 only.
// RULE18 - large: pointer bit 7 picks block; software changes it separately.
// RULE19 - full 8-bit write to the pointer replaces all bits.
// RULE20 - large indirect: pointer 01-0f global bank, higher values banks 1-f.
// RULE21 - large: lower block 00-7f, upper block 80-ff.
// RULE22 - decoder parameterised by variant, address formed combinationally.
`include "bdma_consts.vh"

module bdma_banked_mem #(
    parameter VARIANT     = `BDMA_VARIANT_SMALL,
    parameter HAS_PORT_C  = 1
) (
    // clock, reset, enable
    input  wire       mclk_i,
    input  wire       reset_n_i,
    input  wire       clk_en_i,
    // core access
    input  wire [4:0] register_operand_field_i,
    input  wire       rd_en_i,
    input  wire       wr_en_i,
    input  wire [7:0] wr_data_i,
    // bank-select instruction
    input  wire       bank_sel_i,
    input  wire [7:0] bank_value_i,
    // dedicated register values supplied by the core
    input  wire [7:0] real_time_counter_i,
    input  wire [7:0] program_counter_low_i,
    input  wire [7:0] status_flags_i,
    input  wire [7:0] port_a_data_i,
    input  wire [7:0] port_b_data_i,
    input  wire [7:0] port_c_data_i,
    // read result, dedicated write strobe, pointer copy and decoded physical address
    output reg  [7:0] rd_data_o,
    output reg        rd_valid_o,
    output reg        ded_we_o,
    output reg  [2:0] ded_sel_o,
    output reg  [7:0] ded_data_o,
    output reg  [7:0] file_select_pointer_o,
    output reg  [8:0] paddr_o
);

    // =============================================================
    // memory sizing
    localparam MEM_DEPTH = 272;

    reg  [7:0] mem [0:MEM_DEPTH-1];
    wire [7:0] ptr;
    wire [8:0] paddr;
    reg        is_ded;
    reg        is_ptr;
    reg  [7:0] ded_rd;

    // =============================================================
    // classify the decoded location
    function ded_loc;
        input [8:0] a;
        begin
            if (VARIANT == `BDMA_VARIANT_SMALL)
                ded_loc = (a[8:3] == 6'h00) &&
                          !(a[7:0] == `BDMA_LOC_PORT_C && !HAS_PORT_C); // [RULE12] [RULE11]
            else
                ded_loc = (a[8:3] == 6'h20) &&
                          !(a[2:0] == `BDMA_LOC_PORT_C && !HAS_PORT_C);
        end
    endfunction

    bdma_addr_decode #(
        .VARIANT    (VARIANT)
    ) u_dec (
        .opnd_i     (register_operand_field_i),
        .ptr_i      (ptr),
        .paddr_o    (paddr),
        .indirect_o ()
    );                                                                  // [RULE22]

    always @* begin
        is_ded = ded_loc(paddr);
        is_ptr = is_ded && (paddr[2:0] == `BDMA_LOC_FILE_SELECT);       // [RULE8]
        case (paddr[2:0])
            3'h1:    ded_rd = real_time_counter_i;
            3'h2:    ded_rd = program_counter_low_i;
            3'h3:    ded_rd = status_flags_i;
            3'h4:    ded_rd = ptr;
            3'h5:    ded_rd = port_a_data_i;
            3'h6:    ded_rd = port_b_data_i;
            3'h7:    ded_rd = port_c_data_i;
            // window through a zero pointer points at itself: reads zero
            default: ded_rd = 8'h00;
        endcase
    end

    bdma_pointer #(
        .VARIANT     (VARIANT)
    ) u_ptr (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .full_we_i   (wr_en_i && is_ptr),
        .full_data_i (wr_data_i),
        .bank_we_i   (bank_sel_i),
        .bank_data_i (bank_value_i),
        .ptr_o       (ptr)
    );                                                                  // [RULE19] [RULE4]

    // =============================================================
    // storage: general registers only, no reset needed
    always @(posedge mclk_i) begin
        if (clk_en_i && wr_en_i && !is_ded)
            mem[paddr] <= wr_data_i;                                    // [RULE1] [RULE7]
    end

    // =============================================================
    // registered outputs
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o             <= 8'h00;
            rd_valid_o            <= 1'b0;
            ded_we_o              <= 1'b0;
            ded_sel_o             <= 3'h0;
            ded_data_o            <= 8'h00;
            file_select_pointer_o <= `BDMA_PTR_RESET;                   // [RULE5]
            paddr_o               <= 9'h000;
        end else if (clk_en_i) begin
            rd_valid_o            <= rd_en_i;
            rd_data_o             <= rd_en_i ? (is_ded ? ded_rd : mem[paddr]) : 8'h00;
            ded_we_o              <= wr_en_i && is_ded && !is_ptr &&
                                     (paddr[2:0] != 3'h0);
            ded_sel_o             <= paddr[2:0];
            ded_data_o            <= wr_data_i;
            file_select_pointer_o <= ptr;
            paddr_o               <= paddr;
        end
    end

endmodule

// file: sim/bdma_core_model.sv
// bdma_core_model.sv: core-side holder of the dedicated registers
module bdma_core_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    // dedicated write strobe
    input  wire logic       ded_we_i,
    input  wire logic [2:0] ded_sel_i,
    input  wire logic [7:0] ded_data_i,
    // dedicated values, byte n is location n
    output logic      [63:0] ded_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] r [0:7];
    // distinct reset values so a wrong location reads back wrong
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 8; i++) r[i] <= 8'h10 + 8'(i);
        end else if (ded_we_i) begin
            r[ded_sel_i] <= ded_data_i;
        end
    end
    always_comb for (int i = 0; i < 8; i++) ded_o[i*8 +: 8] = r[i];
endmodule

// file: sim/bdma_banked_mem_properties.sv
// bdma_banked_mem_properties.sv: port assertions of the banked memory decoder
module bdma_props #(
    parameter int VARIANT = 0
) (
    // clock, reset and requests
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       clk_en_i,
    input wire logic [4:0] register_operand_field_i,
    input wire logic       rd_en_i,
    input wire logic       wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       bank_sel_i,
    // results
    input wire logic       rd_valid_o,
    input wire logic       ded_we_o,
    input wire logic [2:0] ded_sel_o,
    input wire logic [7:0] ded_data_o,
    input wire logic [7:0] file_select_pointer_o,
    input wire logic [8:0] paddr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pointer bits that a bank-select must leave alone
    localparam logic [7:0] KEEP = (VARIANT == 1) ? 8'h8f : 8'h1f;
    wire [4:0] op = register_operand_field_i;
    wire       go = clk_en_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // =====
    // pointer update steps
    sequence s_ptr_wr;
        wr_en_i && go && op == 5'h04 ##1 go;
    endsequence
    sequence s_bank_only;
        bank_sel_i && go && !wr_en_i ##1 go && !wr_en_i;
    endsequence
    // =====
    // properties
    chk_read_answer: assert property (rd_en_i && go |=> rd_valid_o)
        else $error("read not answered");
    chk_read_idle: assert property (!rd_en_i && go |=> !rd_valid_o)
        else $error("read valid without request");
    chk_global_direct: assert property (go && op != 5'h00 && !op[4]
        |=> paddr_o == ((VARIANT == 1) ? {5'h10, $past(op[3:0])} : {4'h0, $past(op)}))
        else $error("global address wrong");
    chk_banked_direct: assert property (go && op[4]
        |=> paddr_o == ((VARIANT == 1) ?
                        {1'b0, file_select_pointer_o[7:4], $past(op[3:0])} :
                        {1'b0, file_select_pointer_o[7:5], $past(op)}))
        else $error("banked address wrong");
    chk_indirect_addr: assert property ((go && op == 5'h00) ##1 file_select_pointer_o[4]
        |-> paddr_o == {1'b0, file_select_pointer_o}) else $error("indirect address wrong");
    chk_reset_bank: assert property ($rose(reset_n_i) |-> file_select_pointer_o == 8'h00)
        else $error("pointer not bank 0 after reset");
    chk_bank_keeps: assert property (s_bank_only
        |=> (file_select_pointer_o & KEEP) == ($past(file_select_pointer_o) & KEEP))
        else $error("bank select touched other pointer bits");
    chk_freeze_hold: assert property (!go
        |=> $stable(file_select_pointer_o) && $stable(rd_valid_o) && $stable(paddr_o))
        else $error("outputs moved while frozen");
    chk_full_write: assert property (s_ptr_wr |=> file_select_pointer_o == $past(wr_data_i, 2))
        else $error("full pointer write lost");
    chk_ded_strobe: assert property (go && wr_en_i && op inside {[1:3], [5:7]}
        |=> ded_we_o && ded_sel_o == $past(op[2:0]) && ded_data_o == $past(wr_data_i))
        else $error("dedicated write not passed on");
endmodule
bind bdma_banked_mem bdma_props #(.VARIANT(VARIANT)) u_props (.*);

// file: sim/test_banked_data_memory_addressing.sv
// test_banked_data_memory_addressing.sv: self-checking bench of the banked memory decoder
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_banked_data_memory_addressing;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        clk_en_i = 1'b1;
    logic        rd_en_i = 1'b0;
    logic        wr_en_i = 1'b0;
    logic        bank_sel_i = 1'b0;
    logic [4:0]  register_operand_field_i = 5'h00;
    logic [7:0]  wr_data_i = 8'h00;
    logic [7:0]  bank_value_i = 8'h00;
    logic [7:0]  rd_data_o, ded_data_o, file_select_pointer_o;
    logic        rd_valid_o, ded_we_o;
    logic [2:0]  ded_sel_o;
    logic [8:0]  paddr_o;
    logic [63:0] ded;
    logic [7:0]  rd_data_l, fsp_l, ql;
    logic        rd_valid_l;
    int          miscompares = 0;
    int          compares = 0;
    wire [7:0]   real_time_counter_i = ded[15:8];
    wire [7:0]   program_counter_low_i = ded[23:16];
    wire [7:0]   status_flags_i = ded[31:24];
    wire [7:0]   port_a_data_i = ded[47:40];
    wire [7:0]   port_b_data_i = ded[55:48];
    wire [7:0]   port_c_data_i = ded[63:56];
    bdma_banked_mem uut (.*);
    bdma_core_model u_core (.mclk_i, .reset_n_i, .ded_we_i(ded_we_o), .ded_sel_i(ded_sel_o),
                            .ded_data_i(ded_data_o), .ded_o(ded));
    // large map sees the same stimulus; only its own checks look at it
    bdma_banked_mem #(.VARIANT(1)) uut_large (.mclk_i, .reset_n_i, .clk_en_i,
        .register_operand_field_i, .rd_en_i, .wr_en_i, .wr_data_i, .bank_sel_i, .bank_value_i,
        .real_time_counter_i, .program_counter_low_i, .status_flags_i, .port_a_data_i,
        .port_b_data_i, .port_c_data_i, .rd_data_o(rd_data_l), .rd_valid_o(rd_valid_l),
        .ded_we_o(), .ded_sel_o(), .ded_data_o(), .file_select_pointer_o(fsp_l), .paddr_o());
    // =====
    // bus cycles
    task automatic cyc(input [4:0] op, input r, input w, input [7:0] d, input b);
        @(posedge mclk_i);
        register_operand_field_i <= op;
        rd_en_i <= r;
        wr_en_i <= w;
        wr_data_i <= d;
        bank_sel_i <= b;
        bank_value_i <= d;
    endtask
    task automatic wr(input [4:0] op, input [7:0] d);
        cyc(op, 1'b0, 1'b1, d, 1'b0);
    endtask
    task automatic bank(input [7:0] v);
        cyc(5'h00, 1'b0, 1'b0, v, 1'b1);
    endtask
    // two idle edges let registered outputs and the core catch up
    task automatic settle;
        cyc(5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        cyc(5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        #1;
    endtask
    task automatic rd(input [4:0] op, output [7:0] q);
        cyc(op, 1'b1, 1'b0, 8'h00, 1'b0);
        cyc(5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        #1;
        q = rd_data_o;
        ql = rd_data_l;
        `CHK("valid", 1'b1, rd_valid_o)
        `CHK("large valid", 1'b1, rd_valid_l)
    endtask
    // =====
    // scenarios
    task automatic t_global;
        logic [7:0] q;
        wr(5'h0a, 8'h3c);
        bank(8'he0);
        rd(5'h0a, q);
        `CHK("global", 8'h3c, q)
        rd(5'h01, q);
        `CHK("counter", 8'h11, q)
        wr(5'h05, 8'h5a);
        settle;
        rd(5'h05, q);
        `CHK("port a", 8'h5a, q)
    endtask
    task automatic t_banked;
        logic [7:0] q;
        for (int b = 0; b < 8; b++) begin
            bank(8'(b << 5));
            wr(5'h13, 8'(b * 17 + 1));
        end
        for (int b = 7; b >= 0; b--) begin
            bank(8'(b << 5));
            rd(5'h13, q);
            `CHK("banked", 8'(b * 17 + 1), q)
        end
    endtask
    task automatic t_pointer;
        logic [7:0] q;
        bank(8'ha0);
        wr(5'h15, 8'h77);
        wr(5'h04, 8'hb5);
        rd(5'h00, q);
        `CHK("indirect", 8'h77, q)
        wr(5'h00, 8'h99);
        rd(5'h15, q);
        `CHK("semi", 8'h99, q)
        rd(5'h04, q);
        `CHK("pointer read", 8'hb5, q)
        bank(8'h5f);
        settle;
        `CHK("pointer", 8'h55, file_select_pointer_o)
    endtask
    task automatic t_freeze;
        logic [7:0] q;
        wr(5'h04, 8'h6b);
        cyc(5'h04, 1'b1, 1'b1, 8'h2d, 1'b1);
        clk_en_i <= 1'b0;
        cyc(5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        clk_en_i <= 1'b1;
        #1;
        `CHK("frozen valid", 1'b0, rd_valid_o)
        settle;
        `CHK("frozen pointer", 8'h6b, file_select_pointer_o)
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK("mid reset pointer", 8'h00, file_select_pointer_o)
        settle;
        rd(5'h13, q);
        `CHK("bank 0 after reset", 8'h01, q)
    endtask
    task automatic t_large;
        logic [7:0] q;
        wr(5'h04, 8'h80);
        bank(8'h30);
        settle;
        `CHK("large pointer", 8'hb0, fsp_l)
        wr(5'h1c, 8'h6d);
        wr(5'h0c, 8'h2e);
        wr(5'h04, 8'hb5);
        rd(5'h1c, q);
        `CHK("large semi", 8'h6d, ql)
        rd(5'h0c, q);
        `CHK("large direct", 8'h2e, ql)
        wr(5'h04, 8'hbc);
        rd(5'h00, q);
        `CHK("large indirect", 8'h6d, ql)
        wr(5'h04, 8'h0c);
        rd(5'h00, q);
        `CHK("large ind global", 8'h2e, ql)
        wr(5'h13, 8'h41);
        wr(5'h04, 8'h03);
        rd(5'h00, q);
        `CHK("large no bank 0", 8'h13, ql)
        rd(5'h13, q);
        `CHK("large bank 0", 8'h41, ql)
    endtask
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK("reset pointer", 8'h00, file_select_pointer_o)
        t_global;
        t_banked;
        t_pointer;
        t_freeze;
        t_large;
        complete_run;
    end
    // whole run is near 115 cycles
    initial begin
        repeat (1000) @(posedge mclk_i);
        miscompares++;
        complete_run;
    end
endmodule
